/* rtl/hgls_defs.svh */
`ifndef HGLS_DEFS_SVH
`define HGLS_DEFS_SVH
// ***********************************************************
// Clock and link timing
// ***********************************************************
`define HGLS_CLK_HZ      200000000
`define HGLS_BAUD        19200
`define HGLS_BAUD_DIV    ((`HGLS_CLK_HZ + `HGLS_BAUD / 2) / `HGLS_BAUD)
`define HGLS_MS_DIV      (`HGLS_CLK_HZ / 1000)
// ***********************************************************
// Indicator timing, in millisecond ticks
// ***********************************************************
`define HGLS_BLINK_PERIOD_MS 12'd3000
`define HGLS_BLINK_OFF_MS    12'd150
`define HGLS_FAULT_HALF_MS   12'd250
// ***********************************************************
// Position reporting and host bytes
// ***********************************************************
`define HGLS_REPORT_RES  16'd18000
`define HGLS_SCALE_LSB   16
`define HGLS_CMD_START   8'h53
`define HGLS_CMD_QUERY   8'h51
`define HGLS_CMD_TARGET  8'h54
`define HGLS_REPLY_BYTES 3'd4
`endif

/* rtl/hgls_pkg.sv */
package hgls_pkg;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_AUTO  = 5'b00001,
    ST_LINK  = 5'b00010,
    ST_SLEW1 = 5'b00100,
    ST_SLEW2 = 5'b01000,
    ST_ABORT = 5'b10000
  } hgls_state_e;
  // Host byte parser states, one-hot
  typedef enum logic [2:0] {
    RX_CMD  = 3'b001,
    RX_TGT  = 3'b010,
    RX_SEND = 3'b100
  } hgls_rx_e;
  typedef logic [15:0] hgls_pos_t;
endpackage

/* rtl/hgls_uart_if.sv */
interface hgls_uart_if;
  logic       tx_valid;
  logic       tx_ready;
  logic [7:0] tx_data;
  logic       rx_valid;
  logic [7:0] rx_data;
  modport ctl (output tx_valid, tx_data, input tx_ready, rx_valid, rx_data);
  modport phy (input tx_valid, tx_data, output tx_ready, rx_valid, rx_data);
endinterface

/* rtl/hgls_uart.sv */
`include "hgls_defs.svh"
module hgls_uart #(
  parameter int BAUD_DIV = `HGLS_BAUD_DIV
) (
  input  wire logic   clk,      // System clock
  input  wire logic   arst_n,   // Async reset
  input  wire logic   rx_pin,   // Serial in, async
  output logic        tx_pin,   // Serial out
  hgls_uart_if.phy    u         // Byte side
);
  // ***********************************************************
  // Transmitter, 8N1
  // ***********************************************************
  logic [15:0] tx_cnt;
  logic [3:0]  tx_bit;
  logic [8:0]  tx_sh;
  logic        tx_busy;
  wire         tx_tick = (tx_cnt == 16'(BAUD_DIV - 1));
  assign u.tx_ready = ~tx_busy;
  // Start bit, 8 data LSB first, stop bit
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      tx_busy <= 1'b0;
      tx_cnt  <= 16'h0000;
      tx_bit  <= 4'h0;
      tx_sh   <= 9'h1ff;
      tx_pin  <= 1'b1;
    end
    else if (!tx_busy)
    begin
      tx_cnt <= 16'h0000;
      if (u.tx_valid)
      begin
        tx_busy <= 1'b1;
        tx_pin  <= 1'b0;
        tx_sh   <= {1'b1, u.tx_data};
        tx_bit  <= 4'h0;
      end
    end
    else if (tx_tick)
    begin
      tx_cnt <= 16'h0000;
      tx_pin <= tx_sh[0];
      tx_sh  <= {1'b1, tx_sh[8:1]};
      tx_bit <= tx_bit + 4'h1;
      if (tx_bit == 4'h9)
        tx_busy <= 1'b0;
    end
    else
      tx_cnt <= tx_cnt + 16'h0001;
  // ***********************************************************
  // Receiver, sampled mid-bit
  // ***********************************************************
  logic        rx_s1, rx_s2, rx_busy;
  logic [15:0] rx_cnt;
  logic [3:0]  rx_bit;
  logic [7:0]  rx_sh;
  wire         rx_tick = (rx_cnt == 16'(BAUD_DIV - 1));
  // Pin crosses in through two flops
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end
    else
    begin
      rx_s1 <= rx_pin;
      rx_s2 <= rx_s1;
    end
  // Half-bit preload centres the samples; bad stop bit drops the byte
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      rx_busy    <= 1'b0;
      rx_cnt     <= 16'h0000;
      rx_bit     <= 4'h0;
      rx_sh      <= 8'h00;
      u.rx_valid <= 1'b0;
      u.rx_data  <= 8'h00;
    end
    else
    begin
      u.rx_valid <= 1'b0;
      if (!rx_busy)
      begin
        rx_cnt <= 16'(BAUD_DIV / 2);
        rx_bit <= 4'h0;
        if (!rx_s2)
          rx_busy <= 1'b1;
      end
      else if (rx_tick)
      begin
        rx_cnt <= 16'h0000;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rx_s2)
          rx_busy <= 1'b0;
        else if (rx_bit < 4'h9)
          rx_sh <= {rx_s2, rx_sh[7:1]};
        else
        begin
          rx_busy    <= 1'b0;
          u.rx_valid <= rx_s2;
          u.rx_data  <= rx_sh;
        end
      end
      else
        rx_cnt <= rx_cnt + 16'h0001;
    end
endmodule

/* rtl/hgls_sequencer.sv */
// Behaviour
// - Positions go to the host scaled to 18000 counts per revolution.
// - Both top keys start the link and drop autonomous modes.
// - With link up and a target known, both top keys start a slew.
// - Any direction key aborts a slew in progress.
// - Both top keys after an abort restart the near slew toward the same target.
// - Top-right key alone toggles tracking.
// - Tracking stopped: LEDs blink off briefly every few seconds.
// - Each GoTo is a near slew then a recomputed exact slew.
// - Skip-encoders option ignores the telescope encoders.
// - Runaway or ramp fault stops that motor and flashes LEDs.
// - Jumper selects old-style handpad decoding.
// - Motor-encoder mode uses motor counts as position.
// - Link is 19200 baud, 8 data, no parity, 1 stop.
`include "hgls_defs.svh"
module hgls_sequencer #(
  parameter int BAUD_DIV = `HGLS_BAUD_DIV,
  parameter int MS_DIV   = `HGLS_MS_DIV
) (
  input  wire logic        clk,                   // 200 MHz clock
  input  wire logic        arst_n,                // Async reset
  input  wire logic        top_left_key,          // Pin, high pressed
  input  wire logic        top_right_key,         // Pin, high pressed
  input  wire logic [3:0]  dir_pins,              // Handpad direction pins
  input  wire logic        old_handpad_jumper,    // Pin, old handpad fitted
  input  wire logic        uart_rx,               // Host serial in
  output logic             uart_tx,               // Host serial out
  input  wire logic        skip_scope_encoders,   // Config, ignore scope enc
  input  wire logic        clutch_drag_tracking_mode,   // Config mode
  input  wire logic        motor_encoder_tracking_mode, // Config mode
  input  wire logic [47:0] scope_pos,             // Scope enc {az,alt}
  input  wire logic [47:0] motor_pos,             // Motor enc {az,alt}
  input  wire logic [31:0] scale_factor,          // 18000*2^16/ticks {az,alt}
  input  wire logic        slew_arrived,          // Motion at goal, pulse
  input  wire logic [1:0]  motor_fault,           // Runaway/ramp fault
  output logic             drag_mode_en,          // Clutch-drag mode live
  output logic             motor_enc_mode_en,     // Motor-enc mode live
  output logic             link_active,           // Host link up
  output logic             host_started,          // Start-up byte seen
  output logic             tracking_en,           // Tracking running
  output logic             slew_go,               // Slew start, pulse
  output logic [1:0]       slew_stage,            // 1 near, 2 exact
  output logic             slew_abort,            // Slew stop, pulse
  output logic [31:0]      slew_target,           // Goal {az,alt}
  output logic [3:0]       dir_keys,              // Decoded directions
  output logic [1:0]       motor_stop,            // Motor halted by fault
  output logic [1:0]       led                    // Indicator LEDs
);
  // ***********************************************************
  // Handpad synchronisers and decode
  // ***********************************************************
  logic [5:0] key_s1, key_s2, key_prev;
  // Two flops per pin; the edge detector sees only the second
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      key_s1   <= 6'h00;
      key_s2   <= 6'h00;
      key_prev <= 6'h00;
    end
    else
    begin
      key_s1   <= {old_handpad_jumper, dir_pins, top_right_key ^ 1'b0};
      key_s2   <= key_s1;
      key_prev <= key_s2;
    end
  logic tl_s1, tl_s2, tl_prev;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      tl_s1   <= 1'b0;
      tl_s2   <= 1'b0;
      tl_prev <= 1'b0;
    end
    else
    begin
      tl_s1   <= top_left_key;
      tl_s2   <= tl_s1;
      tl_prev <= tl_s2;
    end
  // Old pad sends a 2-bit code with a strobe on pin 2
  function automatic logic [3:0] hgls_dir_decode(input logic old, input logic [3:0] p);
    if (old)
      hgls_dir_decode = p[2] ? (4'h1 << p[1:0]) : 4'h0;
    else
      hgls_dir_decode = p;
  endfunction
  wire       old_pad    = key_s2[5];
  wire       tr_now     = key_s2[0];
  wire       tr_prev    = key_prev[0];
  wire [3:0] dir_now    = hgls_dir_decode(old_pad, key_s2[4:1]);
  wire [3:0] dir_before = hgls_dir_decode(old_pad, key_prev[4:1]);
  wire       dir_press  = |(dir_now & ~dir_before);
  wire       both_press = tl_s2 & tr_now & ~(tl_prev & tr_prev);
  wire       right_only = tr_now & ~tr_prev & ~tl_s2;
  // ***********************************************************
  // Host byte link
  // ***********************************************************
  hgls_uart_if u ();
  hgls_uart #(.BAUD_DIV(BAUD_DIV)) u_uart (
    .clk    (clk),
    .arst_n (arst_n),
    .rx_pin (uart_rx),
    .tx_pin (uart_tx),
    .u      (u.phy)
  );
  // ***********************************************************
  // Position source and scaling
  // ***********************************************************
  logic [31:0] scaled;
  wire         use_motor = skip_scope_encoders | motor_encoder_tracking_mode;
  for (genvar a = 0; a < 2; a++)
  begin : g_axis
    wire [23:0] src  = use_motor ? motor_pos[a*24 +: 24] : scope_pos[a*24 +: 24];
    wire [39:0] prod = src * scale_factor[a*16 +: 16];
    always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
        scaled[a*16 +: 16] <= 16'h0000;
      else
        scaled[a*16 +: 16] <= prod[`HGLS_SCALE_LSB +: 16];
    always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
        motor_stop[a] <= 1'b0;
      else if (motor_fault[a])
        motor_stop[a] <= 1'b1;
  end
  // ***********************************************************
  // Host parser: start-up, target load, position query
  // ***********************************************************
  hgls_pkg::hgls_rx_e rx_st;
  logic [2:0]  byte_idx;
  logic [31:0] host_target, reply;
  logic        target_valid;
  assign u.tx_valid = (rx_st == hgls_pkg::RX_SEND);
  assign u.tx_data  = reply[31:24];
  // Targets arrive as four bytes, az high first; replies send alt high first
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      rx_st        <= hgls_pkg::RX_CMD;
      byte_idx     <= 3'h0;
      host_target  <= 32'h0000_0000;
      reply        <= 32'h0000_0000;
      target_valid <= 1'b0;
      host_started <= 1'b0;
    end
    else
      case (rx_st)
        hgls_pkg::RX_CMD:
          if (u.rx_valid && link_active)
          begin
            byte_idx <= 3'h0;
            if (u.rx_data == `HGLS_CMD_START)
              host_started <= 1'b1;
            if (u.rx_data == `HGLS_CMD_TARGET)
              rx_st <= hgls_pkg::RX_TGT;
            if (u.rx_data == `HGLS_CMD_QUERY)
            begin
              reply <= {scaled[15:0], scaled[31:16]};
              rx_st <= hgls_pkg::RX_SEND;
            end
          end
        hgls_pkg::RX_TGT:
          if (u.rx_valid)
          begin
            host_target <= {host_target[23:0], u.rx_data};
            byte_idx    <= byte_idx + 3'h1;
            if (byte_idx == `HGLS_REPLY_BYTES - 3'h1)
            begin
              target_valid <= 1'b1;
              rx_st        <= hgls_pkg::RX_CMD;
            end
          end
        hgls_pkg::RX_SEND:
          if (u.tx_ready)
          begin
            reply    <= {reply[23:0], 8'h00};
            byte_idx <= byte_idx + 3'h1;
            if (byte_idx == `HGLS_REPLY_BYTES - 3'h1)
              rx_st <= hgls_pkg::RX_CMD;
          end
        default:
          rx_st <= hgls_pkg::RX_CMD;
      endcase
  // ***********************************************************
  // GoTo sequencer
  // ***********************************************************
  hgls_pkg::hgls_state_e st;
  logic [31:0] goal;
  wire slewing = (st == hgls_pkg::ST_SLEW1) || (st == hgls_pkg::ST_SLEW2);
  // Abort has priority over arrival in the same cycle
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      st          <= hgls_pkg::ST_AUTO;
      goal        <= 32'h0000_0000;
      slew_go     <= 1'b0;
      slew_abort  <= 1'b0;
      slew_stage  <= 2'h0;
      slew_target <= 32'h0000_0000;
    end
    else
    begin
      slew_go    <= 1'b0;
      slew_abort <= 1'b0;
      case (st)
        hgls_pkg::ST_AUTO:
          if (both_press)
            st <= hgls_pkg::ST_LINK;
        hgls_pkg::ST_LINK:
          if (both_press && target_valid)
          begin
            st          <= hgls_pkg::ST_SLEW1;
            goal        <= host_target;
            slew_target <= host_target;
            slew_stage  <= 2'h1;
            slew_go     <= 1'b1;
          end
        hgls_pkg::ST_SLEW1, hgls_pkg::ST_SLEW2:
          if (dir_press)
          begin
            st         <= hgls_pkg::ST_ABORT;
            slew_abort <= 1'b1;
          end
          else if (slew_arrived && st == hgls_pkg::ST_SLEW1)
          begin
            st          <= hgls_pkg::ST_SLEW2;
            slew_target <= host_target;
            slew_stage  <= 2'h2;
            slew_go     <= 1'b1;
          end
          else if (slew_arrived)
          begin
            st         <= hgls_pkg::ST_LINK;
            slew_stage <= 2'h0;
          end
        hgls_pkg::ST_ABORT:
          if (both_press)
          begin
            st          <= hgls_pkg::ST_SLEW1;
            slew_target <= goal;
            slew_stage  <= 2'h1;
            slew_go     <= 1'b1;
          end
        default:
          st <= hgls_pkg::ST_AUTO;
      endcase
    end
  // ***********************************************************
  // Modes, tracking and indicators
  // ***********************************************************
  logic [17:0] ms_cnt;
  logic [11:0] blink_ms, fault_ms;
  logic        ms_tick, flash;
  wire         link_next = (st != hgls_pkg::ST_AUTO);
  // Millisecond enable, then blink and flash timers
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      ms_cnt   <= 18'h00000;
      ms_tick  <= 1'b0;
      blink_ms <= 12'h000;
      fault_ms <= 12'h000;
      flash    <= 1'b0;
    end
    else
    begin
      ms_tick <= (ms_cnt == 18'(MS_DIV - 1));
      ms_cnt  <= (ms_cnt == 18'(MS_DIV - 1)) ? 18'h00000 : ms_cnt + 18'h00001;
      if (ms_tick)
      begin
        blink_ms <= (blink_ms == `HGLS_BLINK_PERIOD_MS - 12'h001) ? 12'h000
                    : blink_ms + 12'h001;
        fault_ms <= (fault_ms == `HGLS_FAULT_HALF_MS - 12'h001) ? 12'h000
                    : fault_ms + 12'h001;
        if (fault_ms == `HGLS_FAULT_HALF_MS - 12'h001)
          flash <= ~flash;
      end
    end
  // Autonomous modes held off while the host owns the mount
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      link_active       <= 1'b0;
      drag_mode_en      <= 1'b0;
      motor_enc_mode_en <= 1'b0;
      tracking_en       <= 1'b1;
      dir_keys          <= 4'h0;
      led               <= 2'b11;
    end
    else
    begin
      link_active       <= link_next;
      drag_mode_en      <= clutch_drag_tracking_mode & ~link_next;
      motor_enc_mode_en <= motor_encoder_tracking_mode & ~link_next;
      dir_keys          <= dir_now;
      if (right_only)
        tracking_en <= ~tracking_en;
      if (|motor_stop)
        led <= {2{flash}};
      else if (!tracking_en)
        led <= {2{blink_ms >= `HGLS_BLINK_OFF_MS}};
      else
        led <= 2'b11;
    end
  // ***********************************************************
  // Checks
  // ***********************************************************
  a_link_start: assert property (@(posedge clk) disable iff (!arst_n)
    st == hgls_pkg::ST_AUTO && both_press |=> ##1 link_active && !drag_mode_en)
    else $error("link not started by top keys");
  a_modes_off: assert property (@(posedge clk) disable iff (!arst_n)
    link_active |-> !drag_mode_en && !motor_enc_mode_en)
    else $error("autonomous mode live with link");
  a_goto_start: assert property (@(posedge clk) disable iff (!arst_n)
    st == hgls_pkg::ST_LINK && both_press && target_valid
    |=> slew_go && slew_stage == 2'h1 && slew_target == $past(host_target))
    else $error("goto did not start");
  a_dir_abort: assert property (@(posedge clk) disable iff (!arst_n)
    slewing && dir_press |=> slew_abort && !slew_go ##1 st == hgls_pkg::ST_ABORT)
    else $error("direction key did not abort");
  a_restart_goal: assert property (@(posedge clk) disable iff (!arst_n)
    st == hgls_pkg::ST_ABORT && both_press |=> slew_go && slew_target == $past(goal))
    else $error("restart used wrong goal");
  a_second_slew: assert property (@(posedge clk) disable iff (!arst_n)
    st == hgls_pkg::ST_SLEW1 && slew_arrived && !dir_press |=> slew_go && slew_stage == 2'h2)
    else $error("second slew missing");
  a_track_toggle: assert property (@(posedge clk) disable iff (!arst_n)
    right_only |=> tracking_en != $past(tracking_en))
    else $error("tracking did not toggle");
  a_fault_stop: assert property (@(posedge clk) disable iff (!arst_n)
    |motor_fault |=> (motor_stop & $past(motor_fault)) == $past(motor_fault)
    ##1 led == {2{$past(flash)}})
    else $error("fault did not stop motor");
  a_led_steady: assert property (@(posedge clk) disable iff (!arst_n)
    tracking_en && motor_stop == 2'b00 |=> led == 2'b11)
    else $error("leds not lit while tracking");
endmodule

/* verif/hgls_host_model.sv */
// ********************************************
// Host pointing computer on the serial port
// ********************************************
module hgls_host_model #(
  parameter int BIT_CYC = 16
) (
  input  wire logic clk,     // Bench clock
  output logic      host_tx, // To device serial in
  input  wire logic host_rx  // From device serial out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line idles high between frames
  initial host_tx = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk);
      host_tx = f[i];
      repeat (BIT_CYC - 1) @(negedge clk);
    end
  endtask
  // mid-bit sampling, stop bit must be high
  task automatic recv_byte(output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    b = 8'h00;
    // Falling edge sampling, clear of the launching edge
    while (host_rx !== 1'b0 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    ok = (n < 4000);
    repeat (BIT_CYC / 2) @(negedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(negedge clk);
      b[i] = host_rx;
    end
    repeat (BIT_CYC) @(negedge clk);
    if (host_rx !== 1'b1)
      ok = 1'b0;
  endtask
endmodule

/* verif/handpad_goto_link_sequencer_tb_top.sv */
// ********************************************
// Sequencer bench
// ********************************************
module handpad_goto_link_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n, top_left_key, top_right_key, old_handpad_jumper, uart_rx, uart_tx;
  logic skip_scope_encoders, clutch_drag_tracking_mode, motor_encoder_tracking_mode;
  logic slew_arrived, drag_mode_en, motor_enc_mode_en, link_active, host_started;
  logic tracking_en, slew_go, slew_abort;
  logic [3:0]  dir_pins, dir_keys, acc;
  logic [47:0] scope_pos, motor_pos;
  logic [31:0] scale_factor, slew_target, tgt, tgt2;
  logic [1:0]  motor_fault, slew_stage, motor_stop, led;
  int          miscompares = 0, total_checks = 0, go_cnt = 0, ab_cnt = 0, n;
  int          seed = 32'h8463676c;
  always #2.5 clk = ~clk;
  hgls_sequencer #(.BAUD_DIV(16), .MS_DIV(20)) u_dut (.clk, .arst_n, .top_left_key,
    .top_right_key, .dir_pins, .old_handpad_jumper, .uart_rx, .uart_tx, .skip_scope_encoders,
    .clutch_drag_tracking_mode, .motor_encoder_tracking_mode, .scope_pos, .motor_pos,
    .scale_factor, .slew_arrived, .motor_fault, .drag_mode_en, .motor_enc_mode_en,
    .link_active, .host_started, .tracking_en, .slew_go, .slew_stage, .slew_abort,
    .slew_target, .dir_keys, .motor_stop, .led);
  hgls_host_model #(.BIT_CYC(16)) u_host (.clk(clk), .host_tx(uart_rx), .host_rx(uart_tx));
  // Pulse counters, so one-cycle strobes are never missed
  always @(posedge clk)
  begin
    go_cnt += (slew_go === 1'b1);
    ab_cnt += (slew_abort === 1'b1);
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Keys held long enough to pass the two-flop synchroniser
  task automatic press(input logic l, input logic r, input logic [3:0] d);
    @(negedge clk);
    top_left_key = l;
    top_right_key = r;
    dir_pins = d;
    repeat (4) @(negedge clk);
    top_left_key = 1'b0;
    top_right_key = 1'b0;
    dir_pins = 4'h0;
    repeat (6) @(negedge clk);
  endtask
  task automatic wait_led(input logic [1:0] v, output int c);
    c = 0;
    while (led !== v && c < 70000)
    begin
      @(negedge clk);
      c++;
    end
  endtask
  function automatic logic [15:0] scl(input logic [23:0] p, input logic [15:0] f);
    logic [39:0] m;
    m = p * f;
    return m[31:16];
  endfunction
  // Host asks for positions; reply is alt then az, high byte first
  task automatic query(input logic [47:0] pos);
    logic [7:0]  b;
    logic [31:0] got;
    bit          ok, all;
    all = 1'b1;
    fork
      u_host.send_byte(8'h51);
      for (int i = 0; i < 4; i++)
      begin
        u_host.recv_byte(b, ok);
        all &= ok;
        got = {got[23:0], b};
      end
    join
    chk(all, 1'b1);
    chk(got, {scl(pos[23:0], scale_factor[15:0]), scl(pos[47:24], scale_factor[31:16])});
  endtask
  task automatic send_tgt(input logic [31:0] t);
    u_host.send_byte(8'h54);
    for (int i = 3; i >= 0; i--)
      u_host.send_byte(t[i*8 +: 8]);
  endtask
  // Watchdog sized well beyond the blink and flash waits
  initial
  begin
    #700000;
    miscompares++;
    close_out();
  end
  initial
  begin
    {arst_n, top_left_key, top_right_key, old_handpad_jumper, skip_scope_encoders} = 5'h00;
    {motor_encoder_tracking_mode, slew_arrived, motor_fault, dir_pins} = 8'h00;
    clutch_drag_tracking_mode = 1'b1;
    scale_factor = $random(seed);
    scope_pos = 48'h000000000000;
    motor_pos = 48'h000000000000;
    repeat (6) @(negedge clk);
    chk({led, tracking_en, link_active, uart_tx}, 5'h1d);
    arst_n = 1'b1;
    motor_encoder_tracking_mode = 1'b1;
    repeat (4) @(negedge clk);
    chk({drag_mode_en, motor_enc_mode_en}, 2'b11);
    {clutch_drag_tracking_mode, motor_encoder_tracking_mode} = 2'b00;
    repeat (3) @(negedge clk);
    chk({drag_mode_en, motor_enc_mode_en}, 2'b00);
    clutch_drag_tracking_mode = 1'b1;
    @(negedge clk);
    press(1'b1, 1'b1, 4'h0);
    chk({link_active, drag_mode_en, go_cnt[1:0]}, 4'h8);
    u_host.send_byte(8'h53);
    repeat (4) @(negedge clk);
    chk(host_started, 1'b1);
    press(1'b1, 1'b1, 4'h0);
    chk(go_cnt, 0);
    tgt = $random(seed);
    send_tgt(tgt);
    press(1'b1, 1'b1, 4'h0);
    chk({go_cnt[3:0], slew_stage, slew_target}, {4'h1, 2'h1, tgt});
    press(1'b0, 1'b0, 4'h1 << ($unsigned($random(seed)) % 4));
    chk(ab_cnt, 1);
    tgt2 = $random(seed);
    send_tgt(tgt2);
    press(1'b1, 1'b1, 4'h0);
    chk({go_cnt[3:0], slew_stage, slew_target}, {4'h2, 2'h1, tgt});
    for (int i = 0; i < 2; i++)
    begin
      @(negedge clk);
      slew_arrived = 1'b1;
      @(negedge clk);
      slew_arrived = 1'b0;
      repeat (3) @(negedge clk);
      chk({go_cnt[3:0], slew_stage}, i == 0 ? 6'h0e : 6'h0c);
    end
    chk(slew_target, tgt2);
    for (int i = 0; i < 4; i++)
    begin
      dir_pins = 4'h1 << i;
      repeat (5) @(negedge clk);
      chk(dir_keys, 4'h1 << i);
    end
    old_handpad_jumper = 1'b1;
    acc = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      dir_pins = {2'b01, i[1:0]};
      repeat (5) @(negedge clk);
      chk($countones(dir_keys), 1);
      acc |= dir_keys;
    end
    chk(acc, 4'hf);
    dir_pins = 4'h0;
    for (int m = 0; m < 3; m++)
    begin
      scope_pos = {24'($unsigned($random(seed)) % 72000), 24'($unsigned($random(seed)) % 36000)};
      motor_pos = {24'($unsigned($random(seed)) % 72000), 24'($unsigned($random(seed)) % 36000)};
      skip_scope_encoders = (m == 1);
      motor_encoder_tracking_mode = (m == 2);
      repeat (4) @(negedge clk);
      query(m == 0 ? scope_pos : motor_pos);
      if (m == 2)
        chk(motor_enc_mode_en, 1'b0);
    end
    press(1'b0, 1'b1, 4'h0);
    chk(tracking_en, 1'b0);
    wait_led(2'b11, n);
    wait_led(2'b00, n);
    chk(n < 70000, 1'b1);
    wait_led(2'b11, n);
    chk(n >= 2990 && n <= 3010, 1'b1);
    press(1'b0, 1'b1, 4'h0);
    chk(tracking_en, 1'b1);
    @(negedge clk);
    motor_fault = 2'b10;
    @(negedge clk);
    motor_fault = 2'b00;
    repeat (3) @(negedge clk);
    chk(motor_stop, 2'b10);
    // Start from a full half period, not the one already running
    wait_led(2'b11, n);
    wait_led(2'b00, n);
    wait_led(2'b11, n);
    chk(n >= 4990 && n <= 5010, 1'b1);
    close_out();
  end
endmodule
